// *** core/rtt_map.vh ***
// named constants shared by the reset-test and test-port block
`ifndef RTT_MAP_VH
`define RTT_MAP_VH
// test port controller states
`define RTT_TLR 4'h0
`define RTT_RTI 4'h1
`define RTT_SDS 4'h2
`define RTT_CDR 4'h3
`define RTT_SDR 4'h4
`define RTT_E1D 4'h5
`define RTT_PDR 4'h6
`define RTT_E2D 4'h7
`define RTT_UDR 4'h8
`define RTT_SIS 4'h9
`define RTT_CIR 4'hA
`define RTT_SIR 4'hB
`define RTT_E1I 4'hC
`define RTT_PIR 4'hD
`define RTT_E2I 4'hE
`define RTT_UIR 4'hF
// instruction register
`define RTT_IR_W 5
`define RTT_IR_CAPT 5'h01
`define RTT_OP_EXTEST 5'h00
`define RTT_OP_SAMPLE 5'h01
`define RTT_OP_RESULT 5'h02
`define RTT_OP_BYPASS 5'h1F
// tms-high count that forces the reset state
`define RTT_TMS_RST 3'h5
// self-test
`define RTT_BIST_CYC 295000
`define RTT_PASS 32'h00000000
`define RTT_RESET_VEC 32'hFFFFFFF0
`define RTT_RES_W 32
`endif

// *** core/rtt_sync.v ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rtt_sync #(
   parameter W = 1
) (
   input  wire         clk_in,
   input  wire         resetn_in,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] lvl_out
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [W-1:0] lvl_q;
   // =========================================
   // level changes only when stages 2 and 3 agree
   always @(posedge clk_in) begin
      if (!resetn_in) begin
         s1_q  <= {W{1'b0}};
         s2_q  <= {W{1'b0}};
         s3_q  <= {W{1'b0}};
         lvl_q <= {W{1'b0}};
      end else begin
         s1_q  <= d_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      end
   end
   assign lvl_out = lvl_q;
endmodule // rtt_sync
`default_nettype wire

// *** core/rtt_fifo.v ***
// small flop-based fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rtt_fifo #(
   parameter W  = 32,
   parameter D  = 4,
   parameter AW = 2
) (
   input  wire          clk_in,
   input  wire          resetn_in,
   input  wire          in_valid_in,
   output wire          in_ready_out,
   input  wire [W-1:0]  in_data_in,
   output wire          out_valid_out,
   input  wire          out_ready_in,
   output wire [W-1:0]  out_data_out
);
   reg [W-1:0]  mem_q [0:D-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0]   cnt_q;
   wire         push;
   wire         pop;
   // =========================================
   // honest full and empty from the fill count
   assign in_ready_out  = (cnt_q != D[AW:0]);
   assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;
   assign out_data_out = mem_q[rd_q];
   // pointers wrap at the depth
   always @(posedge clk_in) begin
      if (!resetn_in) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data_in;
            wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop)
            rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // rtt_fifo
`default_nettype wire

// *** core/rtt_top.v ***
// reset-time self-test, pin-float strap and boundary-scan test port
// How it works
// - self-test always runs after reset release
// - tests icache, dcache, itlb and dtlb
// - result word zero on pass, else fail
// - fetch at reset vector regardless of outcome
// - self-test lasts about 295000 clocks
// - cache-flush low at release selects float mode
// - float mode releases all functional output pins
// - voltage-detect stays low, test output stays driven
// - test port works in every mode
// - float mode ends when reset seen asserted
// - sample on tck rise, drive on fall
// - controller steps on tms at each rise
// - stopped tck, either level, keeps state
// - tdi enters msb, shift per rise
// - tdo from lsb, changes per fall
// - five tms highs force reset state
// - test reset forces reset state asynchronously
// - instruction register plus three data registers
// - non-inverting boundary chain, capture and drive
// - instruction register five bits, no parity
// - instruction capture loads 01 in low bits
`include "rtt_map.vh"
`timescale 1ns/100ps
`default_nettype none
module rtt_top #(
   parameter BIST_CYCLES = `RTT_BIST_CYC,
   parameter NOUT        = 8,
   parameter NIN         = 8,
   parameter FIFO_D      = 4,
   parameter FIFO_AW     = 2
) (
   input  wire            clk_in,
   input  wire            resetn_in,
   input  wire            flush_n_in,
   input  wire            tck_in,
   input  wire            tms_in,
   input  wire            tdi_in,
   input  wire            trst_n_in,
   output wire            tdo_out,
   output wire            core_voltage_detect_out,
   input  wire [NOUT-1:0] func_val_in,
   input  wire [NOUT-1:0] func_oe_in,
   input  wire [NOUT-1:0] pad_rd_in,
   input  wire [NIN-1:0]  pin_in,
   output wire [NOUT-1:0] pad_val_out,
   output wire [NOUT-1:0] pad_oe_out,
   input  wire [3:0]      bist_fail_in,
   output wire [1:0]      bist_target_out,
   output wire            bist_busy_out,
   output wire            bist_done_out,
   output wire [31:0]     accumulator_result_out,
   output wire            fetch_go_out,
   output wire [31:0]     fetch_addr_out,
   output wire            float_mode_out,
   output wire            res_valid_out,
   output wire [31:0]     res_data_out,
   input  wire            res_ready_in
);
   localparam BSR_LEN = 2 * NOUT + NIN;
   localparam [18:0] PH_LAST = BIST_CYCLES / 4 - 1;

   // =========================================
   // input synchronisers
   wire [2:0]        tap_lvl;
   wire [NOUT+NIN:0] pin_lvl;
   rtt_sync #(.W(3)) u_tap_sync (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .d_in      ({tck_in, tms_in, tdi_in}),
      .lvl_out   (tap_lvl)
   );
   // pin levels keep tracking through reset, so the strap is
   // already valid at the first edge after release
   rtt_sync #(.W(NOUT+NIN+1)) u_pin_sync (
      .clk_in    (clk_in),
      .resetn_in (1'b1),
      .d_in      ({flush_n_in, pin_in, pad_rd_in}),
      .lvl_out   (pin_lvl)
   );
   wire            tck_l   = tap_lvl[2];
   wire            tms_l   = tap_lvl[1];
   wire            tdi_l   = tap_lvl[0];
   wire            flush_l = pin_lvl[NOUT+NIN];
   wire [NIN-1:0]  in_l    = pin_lvl[NOUT+NIN-1:NOUT];
   wire [NOUT-1:0] rd_l    = pin_lvl[NOUT-1:0];

   // =========================================
   // reset strap and self-test sequencer
   reg        up_q;
   reg        float_q;
   reg        busy_q;
   reg        done_q;
   reg        go_q;
   reg [1:0]  phase_q;
   reg [18:0] cnt_q;
   reg [3:0]  fail_q;
   reg [31:0] result_q;
   wire       fifo_rdy;
   wire       ph_end  = busy_q & (cnt_q == PH_LAST);
   wire       push    = ph_end;
   wire [3:0] fail_d;
   // fail bits gather per tested structure
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_fail
         assign fail_d[g] = fail_q[g] |
            (busy_q & (phase_q == g) & bist_fail_in[g]);
      end
   endgenerate
   // first clock after release starts the test
   always @(posedge clk_in) begin
      if (!resetn_in) begin
         up_q     <= 1'b0;
         float_q  <= 1'b0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         go_q     <= 1'b0;
         phase_q  <= 2'h0;
         cnt_q    <= 19'h00000;
         fail_q   <= 4'h0;
         result_q <= `RTT_PASS;
      end else begin
         up_q   <= 1'b1;
         go_q   <= 1'b0;
         fail_q <= fail_d;
         if (!up_q) begin
            float_q <= ~flush_l;
            busy_q  <= 1'b1;
         end
         // a full fifo holds the count until space frees
         if (busy_q) begin
            if (!ph_end)
               cnt_q <= cnt_q + 19'h00001;
            else if (fifo_rdy) begin
               cnt_q   <= 19'h00000;
               phase_q <= phase_q + 2'h1;
               if (phase_q == 2'h3) begin
                  busy_q   <= 1'b0;
                  done_q   <= 1'b1;
                  go_q     <= 1'b1;
                  result_q <= {28'h0000000, fail_d};
               end
            end
         end
      end
   end
   assign bist_target_out        = phase_q;
   assign bist_busy_out          = busy_q;
   assign bist_done_out          = done_q;
   assign accumulator_result_out = result_q;
   assign fetch_go_out           = go_q;
   assign fetch_addr_out         = `RTT_RESET_VEC;
   assign float_mode_out         = float_q;

   // per-phase status words, back-pressure stalls the sequencer
   rtt_fifo #(.W(32), .D(FIFO_D), .AW(FIFO_AW)) u_fifo (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (push),
      .in_ready_out  (fifo_rdy),
      .in_data_in    ({26'h0000000, phase_q, fail_d}),
      .out_valid_out (res_valid_out),
      .out_ready_in  (res_ready_in),
      .out_data_out  (res_data_out)
   );

   // =========================================
   // tck edge detection on the filtered level
   // reset level matches the idle low tck, so no false edge
   reg  tck_p_q;
   wire rise = tck_l & ~tck_p_q;
   wire fall = ~tck_l & tck_p_q;
   always @(posedge clk_in) begin
      if (!resetn_in)
         tck_p_q <= 1'b0;
      else
         tck_p_q <= tck_l;
   end

   // =========================================
   // test port controller
   reg [3:0]         st_q;
   reg [3:0]         st_d;
   reg [2:0]         ones_q;
   reg [4:0]         ir_sr_q;
   reg [4:0]         ir_q;
   reg [BSR_LEN-1:0] bsr_sr_q;
   reg [BSR_LEN-1:0] bsr_up_q;
   reg [31:0]        res_sr_q;
   reg               byp_q;
   reg               tdo_q;
   wire [BSR_LEN-1:0] bsr_cap;
   // next state from tms
   always @* begin
      case (st_q)
         `RTT_TLR: st_d = tms_l ? `RTT_TLR : `RTT_RTI;
         `RTT_RTI: st_d = tms_l ? `RTT_SDS : `RTT_RTI;
         `RTT_SDS: st_d = tms_l ? `RTT_SIS : `RTT_CDR;
         `RTT_CDR: st_d = tms_l ? `RTT_E1D : `RTT_SDR;
         `RTT_SDR: st_d = tms_l ? `RTT_E1D : `RTT_SDR;
         `RTT_E1D: st_d = tms_l ? `RTT_UDR : `RTT_PDR;
         `RTT_PDR: st_d = tms_l ? `RTT_E2D : `RTT_PDR;
         `RTT_E2D: st_d = tms_l ? `RTT_UDR : `RTT_SDR;
         `RTT_UDR: st_d = tms_l ? `RTT_SDS : `RTT_RTI;
         `RTT_SIS: st_d = tms_l ? `RTT_TLR : `RTT_CIR;
         `RTT_CIR: st_d = tms_l ? `RTT_E1I : `RTT_SIR;
         `RTT_SIR: st_d = tms_l ? `RTT_E1I : `RTT_SIR;
         `RTT_E1I: st_d = tms_l ? `RTT_UIR : `RTT_PIR;
         `RTT_PIR: st_d = tms_l ? `RTT_E2I : `RTT_PIR;
         `RTT_E2I: st_d = tms_l ? `RTT_UIR : `RTT_SIR;
         `RTT_UIR: st_d = tms_l ? `RTT_SDS : `RTT_RTI;
         default:  st_d = `RTT_TLR;
      endcase
   end
   // boundary capture: value from the pad, enable as driven
   generate
      for (g = 0; g < NOUT; g = g + 1) begin : g_bcap
         assign bsr_cap[2*g]   = rd_l[g];
         assign bsr_cap[2*g+1] = pad_oe_out[g];
      end
   endgenerate
   assign bsr_cap[BSR_LEN-1:2*NOUT] = in_l;
   wire sel_bsr = (ir_q == `RTT_OP_EXTEST) | (ir_q == `RTT_OP_SAMPLE);
   wire sel_res = (ir_q == `RTT_OP_RESULT);
   wire extest  = (ir_q == `RTT_OP_EXTEST);
   wire dr_lsb  = sel_bsr ? bsr_sr_q[0] : (sel_res ? res_sr_q[0] : byp_q);
   // state only moves on a tck edge, so a stopped tck holds all
   always @(posedge clk_in or negedge trst_n_in) begin
      if (!trst_n_in) begin
         st_q     <= `RTT_TLR;
         ones_q   <= 3'h0;
         ir_sr_q  <= `RTT_IR_CAPT;
         ir_q     <= `RTT_OP_BYPASS;
         bsr_sr_q <= {BSR_LEN{1'b0}};
         bsr_up_q <= {BSR_LEN{1'b0}};
         res_sr_q <= 32'h00000000;
         byp_q    <= 1'b0;
         tdo_q    <= 1'b0;
      end else if (!resetn_in) begin
         st_q     <= `RTT_TLR;
         ones_q   <= 3'h0;
         ir_sr_q  <= `RTT_IR_CAPT;
         ir_q     <= `RTT_OP_BYPASS;
         bsr_sr_q <= {BSR_LEN{1'b0}};
         bsr_up_q <= {BSR_LEN{1'b0}};
         res_sr_q <= 32'h00000000;
         byp_q    <= 1'b0;
         tdo_q    <= 1'b0;
      end else if (rise) begin
         ones_q <= tms_l ? ((ones_q == `RTT_TMS_RST) ? ones_q : ones_q + 3'h1) : 3'h0;
         if (tms_l && (ones_q == `RTT_TMS_RST - 3'h1))
            st_q <= `RTT_TLR;
         else
            st_q <= st_d;
         case (st_q)
            `RTT_TLR: ir_q <= `RTT_OP_BYPASS;
            `RTT_CIR: ir_sr_q <= `RTT_IR_CAPT;
            `RTT_SIR: ir_sr_q <= {tdi_l, ir_sr_q[4:1]};
            `RTT_UIR: ir_q <= ir_sr_q;
            `RTT_CDR: begin
               if (sel_bsr)
                  bsr_sr_q <= bsr_cap;
               res_sr_q <= result_q;
               byp_q    <= 1'b0;
            end
            `RTT_SDR: begin
               if (sel_bsr)
                  bsr_sr_q <= {tdi_l, bsr_sr_q[BSR_LEN-1:1]};
               else if (sel_res)
                  res_sr_q <= {tdi_l, res_sr_q[31:1]};
               else
                  byp_q <= tdi_l;
            end
            `RTT_UDR: begin
               if (sel_bsr)
                  bsr_up_q <= bsr_sr_q;
            end
            default: ;
         endcase
      end else if (fall) begin
         tdo_q <= (st_q == `RTT_SIR) ? ir_sr_q[0] : dr_lsb;
      end
   end
   // tdo has no enable, so it keeps driving in float mode
   assign tdo_out = tdo_q;

   // =========================================
   // pad drive: extest, float mode, or functional
   generate
      for (g = 0; g < NOUT; g = g + 1) begin : g_pad
         assign pad_val_out[g] = extest ? bsr_up_q[2*g] : func_val_in[g];
         // extest wins over the float strap, the port stays usable
         assign pad_oe_out[g]  = extest ? bsr_up_q[2*g+1] :
                                 (~float_q & func_oe_in[g]);
      end
   endgenerate
   // supply-select output is never floated
   assign core_voltage_detect_out = 1'b0;
endmodule // rtt_top
`default_nettype wire

// *** dv/rtt_top_monitor.sv ***
// assertion checker for the reset-test and test-port block
`timescale 1ns/100ps
`default_nettype none
module rtt_top_monitor #(
   parameter BIST_CYCLES = 400
) (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        flush_n_in,
   input wire logic        tck_in,
   input wire logic        trst_n_in,
   input wire logic        tdo_out,
   input wire logic        core_voltage_detect_out,
   input wire logic        bist_busy_out,
   input wire logic        bist_done_out,
   input wire logic [31:0] accumulator_result_out,
   input wire logic        fetch_go_out,
   input wire logic [31:0] fetch_addr_out,
   input wire logic        float_mode_out
);
   // ==========================================
   // busy cycle counter, one run per reset
   logic [19:0] cnt_q;
   always @(posedge clk_in) begin
      if (!resetn_in)
         cnt_q <= 20'h00000;
      else if (bist_busy_out)
         cnt_q <= cnt_q + 20'h00001;
   end
   // ==========================================
   // properties
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   AST_START: assert property ($rose(resetn_in) |=> bist_busy_out [*8])
      else $error("self-test did not start after reset");
   AST_LEN_MIN: assert property ($fell(bist_busy_out) |-> cnt_q >= BIST_CYCLES - 4)
      else $error("self-test ended too early");
   AST_LEN_MAX: assert property (bist_busy_out |-> cnt_q <= BIST_CYCLES + 16)
      else $error("self-test runs too long");
   AST_DONE_GO: assert property ($rose(bist_done_out) |-> fetch_go_out
      && $fell(bist_busy_out) && accumulator_result_out[31:4] == 28'h0000000)
      else $error("completion without fetch start");
   AST_GO_PULSE: assert property (fetch_go_out |=> !fetch_go_out && bist_done_out)
      else $error("fetch start not a single pulse");
   AST_ADDR: assert property (fetch_go_out |-> fetch_addr_out == 32'hFFFFFFF0)
      else $error("wrong fetch address");
   AST_HOLD: assert property ($past(bist_done_out) && bist_done_out
      |-> $stable(accumulator_result_out))
      else $error("result word changed after completion");
   AST_VDET: assert property (core_voltage_detect_out == 1'b0)
      else $error("voltage detect not low");
   AST_FLOAT_IN: assert property ($rose(resetn_in) |=> float_mode_out == !$past(flush_n_in))
      else $error("float mode does not follow strap");
   AST_FLOAT_CLR: assert property ($rose(resetn_in) |-> !float_mode_out)
      else $error("float mode survived reset");
   AST_TDO_FALL: assert property ($changed(tdo_out) |-> !tck_in)
      else $error("tdo changed while tck high");
   AST_TRST: assert property (!trst_n_in |-> tdo_out == 1'b0)
      else $error("tdo not cleared by test reset");
endmodule // rtt_top_monitor
`default_nettype wire

// *** dv/rtt_jtag_host.sv ***
// test-port controller model driving tck, tms and tdi
`timescale 1ns/100ps
`default_nettype none
module rtt_jtag_host (
   output var logic tck_out,
   output var logic tms_out,
   output var logic tdi_out,
   input  wire logic tdo_in
);
   int stall_ns = 0; // extra time with tck stopped high
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   // one tck period of 160 ns, tdo taken just before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms_out = m;
      tdi_out = d;
      #80;
      q = tdo_in;
      tck_out = 1'b1;
      #(80 + stall_ns);
      tck_out = 1'b0;
   endtask
   // five highs reach the reset state, then idle
   task automatic idle_reset();
      logic q;
      #3;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      tdi_out = ~tdi_out; // released line shows no stale value
   endtask
   // whole scan from idle back to idle, lsb first
   task automatic scan(input logic ir, input logic [63:0] din, input int n,
                       output logic [63:0] dout);
      logic q;
      dout = 64'h0;
      #3;
      step(1'b1, 1'b0, q);
      if (ir)
         step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, ~din[n-1], q);
   endtask
endmodule // rtt_jtag_host
`default_nettype wire

// *** dv/rtt_top_tb.sv ***
// self-checking bench for the reset-test and test-port block
`timescale 1ns/100ps
`default_nettype none
module rtt_top_tb;
   localparam int BIST = 400;
   logic        clk_in, resetn_in, flush_n_in, trst_n_in, res_ready_in;
   logic        tck, tms, tdi, tdo, busy, done, go, flt, rvalid;
   logic [7:0]  fval, foe, prd, pin, pval, poe;
   logic [3:0]  fail;
   logic [1:0]  tgt;
   logic        cvd;
   logic [31:0] acc, faddr, rdata;
   logic [63:0] dout, din;
   logic [15:0] sp;
   int          n;
   int          bad_count = 0;
   int          total_checks = 0;
   rtt_top #(.BIST_CYCLES(BIST)) uut (
      .clk_in(clk_in), .resetn_in(resetn_in), .flush_n_in(flush_n_in), .tck_in(tck),
      .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n_in), .tdo_out(tdo),
      .core_voltage_detect_out(cvd), .func_val_in(fval), .func_oe_in(foe), .pad_rd_in(prd),
      .pin_in(pin), .pad_val_out(pval), .pad_oe_out(poe), .bist_fail_in(fail),
      .bist_target_out(tgt), .bist_busy_out(busy), .bist_done_out(done),
      .accumulator_result_out(acc), .fetch_go_out(go), .fetch_addr_out(faddr),
      .float_mode_out(flt), .res_valid_out(rvalid), .res_data_out(rdata),
      .res_ready_in(res_ready_in));
   rtt_jtag_host u_host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
   // ==========================================
   // clock and checking helpers
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // functional pads, floated when the strap mode is on
   function automatic logic [15:0] pad_exp(input logic f);
      return {f ? 8'h00 : foe, fval};
   endfunction
   // chain order to {enables, values}
   function automatic logic [15:0] split(input logic [15:0] v);
      for (int i = 0; i < 8; i++) begin
         split[i] = v[2*i];
         split[i+8] = v[2*i+1];
      end
   endfunction
   task automatic ir(input logic [4:0] op);
      u_host.scan(1'b1, {54'h0, op, 5'h15}, 10, dout);
      cmp("ir capture", 64'h01, dout[4:0]);
      cmp("ir length", 64'h15, dout[9:5]);
   endtask
   // ==========================================
   // watchdog
   initial begin
      #400000;
      bad_count++;
      end_sim();
   end
   // ==========================================
   // main sequence: pass, float strap, all-fail runs
   initial begin
      {resetn_in, flush_n_in, trst_n_in, res_ready_in} = 4'b0110;
      {fval, foe, prd, pin, fail} = 36'h0;
      din[31:0] = $urandom(79);
      for (int k = 0; k < 3; k++) begin
         @(negedge clk_in);
         fail = (k == 0) ? 4'h0 : (k == 2) ? 4'hF : 4'($urandom);
         flush_n_in = (k != 1);
         {fval, foe, prd, pin} = $urandom;
         resetn_in = 1'b0;
         res_ready_in = 1'b0;
         repeat (16) @(negedge clk_in);
         cmp("float in reset", 0, flt);
         resetn_in = 1'b1;
         n = 0;
         while (go !== 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
            if (n % 100 == 50) begin
               cmp("busy", 1, busy);
               cmp("target", n / 100, tgt);
            end
         end
         cmp("fetch start", 1, go);
         cmp("result", {28'h0, fail}, acc);
         cmp("fetch address", 32'hFFFFFFF0, faddr);
         cmp("done", 1, done);
         cmp("float mode", k == 1, flt);
         cmp("voltage detect", 0, cvd);
         cmp("pads", pad_exp(k == 1), {poe, pval});
         // drain the full fifo one word at a time
         for (int i = 0; i < 4; i++) begin
            cmp("fifo valid", 1, rvalid);
            cmp("fifo phase", i, rdata[31:4]);
            cmp("fifo fail", fail & 4'((1 << (i + 1)) - 1), rdata[3:0]);
            res_ready_in = 1'b1;
            @(negedge clk_in);
            res_ready_in = 1'b0;
            @(negedge clk_in);
         end
         cmp("fifo empty", 0, rvalid);
         u_host.idle_reset();
         ir(5'h02);
         u_host.scan(1'b0, 64'h0, 32, dout);
         cmp("result scan", {28'h0, fail}, dout[31:0]);
         u_host.stall_ns = (k == 2) ? 1000 : 0;
         ir(5'h1F);
         din = {$urandom, $urandom};
         u_host.scan(1'b0, din, 16, dout);
         cmp("bypass", {din[14:0], 1'b0}, dout[15:0]);
         u_host.stall_ns = 0;
         ir(5'h01);
         u_host.scan(1'b0, din, 24, dout);
         sp = split(dout[15:0]);
         cmp("sample inputs", pin, dout[23:16]);
         cmp("sample readback", prd, sp[7:0]);
         ir(5'h00);
         u_host.scan(1'b0, din, 24, dout);
         @(negedge clk_in);
         cmp("extest pads", split(din[15:0]), {poe, pval});
         if (k == 1) begin
            trst_n_in = 1'b0;
            repeat (3) @(negedge clk_in);
            cmp("tdo in test reset", 0, tdo);
            trst_n_in = 1'b1;
         end else
            u_host.idle_reset();
         @(negedge clk_in);
         cmp("pads after tap reset", pad_exp(k == 1), {poe, pval});
      end
      end_sim();
   end
endmodule // rtt_top_tb
bind rtt_top rtt_top_monitor #(.BIST_CYCLES(BIST_CYCLES)) u_mon (
   .clk_in(clk_in), .resetn_in(resetn_in), .flush_n_in(flush_n_in), .tck_in(tck_in),
   .trst_n_in(trst_n_in), .tdo_out(tdo_out), .core_voltage_detect_out(core_voltage_detect_out),
   .bist_busy_out(bist_busy_out), .bist_done_out(bist_done_out),
   .accumulator_result_out(accumulator_result_out), .fetch_go_out(fetch_go_out),
   .fetch_addr_out(fetch_addr_out), .float_mode_out(float_mode_out));
`default_nettype wire
